// ===== reset_cause_flags.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module reset_cause_flags
   import reset_cause_pkg::*;
#(
   parameter int PC_W = PC_BITS
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rdata,
   input  wire logic              master_clear_pin_n,
   input  wire logic              brownout_req,
   input  wire logic              low_power_brownout_req,
   input  wire logic              wdt_timeout,
   input  wire logic              window_violation,
   input  wire logic              reset_instr,
   input  wire logic              stack_overflow,
   input  wire logic              stack_underflow,
   input  wire logic              exec_violation,
   input  wire logic              irq_wake,
   input  wire logic              sleeping,
   input  wire logic              global_interrupt_enable,
   input  wire logic              instr_done,
   input  wire logic [PC_W-1:0]   pc_in,
   output logic                   timeout_status,
   output logic                   powerdown_status,
   output logic                   core_reset,
   output logic                   pc_load,
   output logic      [PC_W-1:0]   pc_value,
   output logic                   push_return
);

   typedef struct packed {
      logic [2:0]        pin_sync;
      logic              pin_level;
      logic [7:0]        power_control_flags_0;
      logic              exec_violation_flag;
      logic              to;
      logic              pd;
      logic              stk_en;
      logic [DATA_W-1:0] rdata;
      logic              core_reset;
      logic              pc_load;
      logic [PC_W-1:0]   pc_value;
      logic              push_return;
      logic              vector_pending;
   } state_t;

   state_t s;
   state_t n;

   // Prioritised cause decode, one cause per cycle
   logic pin_fall;
   logic ev_bor;
   logic ev_exec_violation_flag;
   logic ev_pin;
   logic ev_wdt_wake;
   logic ev_wdt;
   logic ev_win;
   logic ev_ri;
   logic ev_ovf;
   logic ev_unf;
   logic ev_irq;
   logic ev_any;

   // Pin filter: a level counts once second and third stage agree
   // A one-cycle glitch on the pin never reaches the decode below
   assign pin_fall = s.pin_level & ~s.pin_sync[2] & ~s.pin_sync[1];

   // Brown-out outranks all, it means the supply is not trustworthy
   assign ev_bor      = brownout_req | low_power_brownout_req;
   assign ev_exec_violation_flag     = ~ev_bor & exec_violation;
   assign ev_pin      = ~ev_bor & ~exec_violation & pin_fall;
   assign ev_wdt_wake = ~ev_bor & ~exec_violation & ~pin_fall
                        & wdt_timeout & sleeping;
   assign ev_wdt      = ~ev_bor & ~exec_violation & ~pin_fall
                        & wdt_timeout & ~sleeping;
   assign ev_win      = ~ev_bor & ~exec_violation & ~pin_fall
                        & ~wdt_timeout & window_violation;
   assign ev_ri       = ~ev_bor & ~exec_violation & ~pin_fall
                        & ~wdt_timeout & ~window_violation & reset_instr;
   assign ev_ovf      = ~ev_bor & ~exec_violation & ~pin_fall
                        & ~wdt_timeout & ~window_violation & ~reset_instr
                        & stack_overflow & s.stk_en;
   assign ev_unf      = ~ev_bor & ~exec_violation & ~pin_fall
                        & ~wdt_timeout & ~window_violation & ~reset_instr
                        & ~(stack_overflow & s.stk_en)
                        & stack_underflow & s.stk_en;
   assign ev_irq      = ~ev_bor & ~exec_violation & ~pin_fall
                        & ~wdt_timeout & ~window_violation & ~reset_instr
                        & ~(stack_overflow & s.stk_en)
                        & ~(stack_underflow & s.stk_en)
                        & irq_wake & sleeping;
   assign ev_any      = ev_bor | ev_exec_violation_flag | ev_pin | ev_wdt_wake | ev_wdt
                        | ev_win | ev_ri | ev_ovf | ev_unf | ev_irq;

   // Next state: bus first, then hardware causes so that a hardware cause wins over a write
   always_comb begin
      n = s;
      n.core_reset  = 1'b0;
      n.pc_load     = 1'b0;
      n.push_return = 1'b0;
      n.rdata       = '0;
      n.pin_sync    = {s.pin_sync[1:0], master_clear_pin_n};
      if (s.pin_sync[1] == s.pin_sync[2]) begin
         n.pin_level = s.pin_sync[2];
      end

      // Register writes; status bits are not writable
      if (wr_en) begin
         case (addr)
            POWER_CONTROL_FLAGS_0_OFS: n.power_control_flags_0 = wdata;
            POWER_CONTROL_FLAGS_1_OFS: n.exec_violation_flag = wdata[EXEC_VIOLATION_FLAG_BIT];
            CTRL_OFS:  n.stk_en = wdata[STK_EN_BIT];
            default:   n.stk_en = s.stk_en;
         endcase
      end

      // Register reads, unmapped offsets answer zero
      if (rd_en) begin
         case (addr)
            STATUS_OFS: begin
               n.rdata[TO_BIT] = s.to;
               n.rdata[PD_BIT] = s.pd;
            end
            POWER_CONTROL_FLAGS_0_OFS: n.rdata = s.power_control_flags_0;
            POWER_CONTROL_FLAGS_1_OFS: n.rdata[EXEC_VIOLATION_FLAG_BIT] = s.exec_violation_flag;
            CTRL_OFS:  n.rdata[STK_EN_BIT] = s.stk_en;
            default:   n.rdata = '0;
         endcase
      end

      // Interrupt vector once the instruction after wake-up retires
      if (s.vector_pending && instr_done) begin
         n.vector_pending = 1'b0;
         n.push_return    = 1'b1;
         n.pc_load        = 1'b1;
         n.pc_value       = PC_W'(IRQ_VEC);
      end

      // Only the causing flag is touched, except on brown-out, which loads its flag image and keeps only the power-on flag
      if (ev_bor) begin
         n.power_control_flags_0 = POWER_CONTROL_FLAGS_0_BOR_SET | (s.power_control_flags_0 & POWER_CONTROL_FLAGS_0_BOR_KEEP);
         n.to    = 1'b1;
         n.pd    = 1'b1;
      end else if (ev_exec_violation_flag) begin
         n.exec_violation_flag = 1'b0;
      end else if (ev_pin) begin
         n.power_control_flags_0[PIN_BIT] = 1'b0;
         if (sleeping) begin
            n.to = 1'b1;
            n.pd = 1'b0;
         end
      end else if (ev_wdt_wake) begin
         n.to = 1'b0;
         n.pd = 1'b0;
      end else if (ev_wdt) begin
         n.power_control_flags_0[WDT_BIT] = 1'b0;
         n.to             = 1'b0;
      end else if (ev_win) begin
         n.power_control_flags_0[WIN_BIT] = 1'b0;
      end else if (ev_ri) begin
         n.power_control_flags_0[RI_BIT] = 1'b0;
      end else if (ev_ovf) begin
         n.power_control_flags_0[OVF_BIT] = 1'b1;
      end else if (ev_unf) begin
         n.power_control_flags_0[UNF_BIT] = 1'b1;
      end else if (ev_irq) begin
         n.to = 1'b1;
         n.pd = 1'b0;
      end

      // Restart or resume; a real reset drops any pending vector
      if (ev_any && !ev_wdt_wake && !ev_irq) begin
         n.core_reset     = 1'b1;
         n.pc_load        = 1'b1;
         n.pc_value       = PC_W'(RESET_VEC);
         n.push_return    = 1'b0;
         n.vector_pending = 1'b0;
      end else if (ev_wdt_wake || ev_irq) begin
         n.pc_load        = 1'b1;
         n.pc_value       = PC_W'(pc_in + PC_W'(1));
         n.push_return    = 1'b0;
         n.vector_pending = ev_irq & global_interrupt_enable;
      end
   end

   // Power-on is the asynchronous reset; only it and a software write clear the power-on flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // Fields not named below start at zero, pulses included
         s                <= '0;
         s.pin_sync       <= 3'h7;
         s.pin_level      <= 1'b1;
         s.power_control_flags_0          <= POWER_CONTROL_FLAGS_0_POR;
         s.exec_violation_flag           <= EXEC_VIOLATION_FLAG_POR;
         s.to             <= 1'b1;
         s.pd             <= 1'b1;
         s.stk_en         <= STK_EN_POR;
         s.pc_value       <= PC_W'(RESET_VEC);
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register
   assign rdata            = s.rdata;
   assign timeout_status   = s.to;
   assign powerdown_status = s.pd;
   assign core_reset       = s.core_reset;
   assign pc_load          = s.pc_load;
   assign pc_value         = s.pc_value;
   assign push_return      = s.push_return;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Interrupt wake steps: resume first, then vector on retirement
   sequence gie_wake_s;
      ev_irq && global_interrupt_enable;
   endsequence

   sequence resume_s;
      pc_load && !core_reset && s.vector_pending;
   endsequence

   sequence vector_s;
      pc_load && push_return && pc_value == PC_W'(IRQ_VEC);
   endsequence

   irq_vector_a: assert property (gie_wake_s |=> resume_s)
      else $error("wake with interrupts enabled did not arm vector");

   vector_jump_a: assert property (s.vector_pending && instr_done && !ev_any
      |=> vector_s)
      else $error("vector jump missing after resumed instruction");

   bor_image_a: assert property (ev_bor |=> !s.power_control_flags_0[BOR_BIT] && s.to && s.pd
      && s.power_control_flags_0[POR_BIT] == $past(s.power_control_flags_0[POR_BIT]) && core_reset)
      else $error("brown-out did not load its flag image");

   pin_run_a: assert property (ev_pin && !sleeping |=> !s.power_control_flags_0[PIN_BIT]
      && $stable({s.to, s.pd}) && pc_value == PC_W'(RESET_VEC))
      else $error("pin reset while running wrong");

   pin_sleep_a: assert property (ev_pin && sleeping
      |=> s.to && !s.pd && core_reset)
      else $error("pin reset in sleep wrong");

   wdt_reset_a: assert property (ev_wdt |=> !s.power_control_flags_0[WDT_BIT] && !s.to
      && $stable(s.pd) && core_reset)
      else $error("watchdog reset wrong");

   window_a: assert property (ev_win && !wr_en |=> !s.power_control_flags_0[WIN_BIT]
      && (s.power_control_flags_0 | 8'h20) == ($past(s.power_control_flags_0) | 8'h20))
      else $error("window violation touched other flags");

   wdt_wake_a: assert property (ev_wdt_wake |=> !s.to && !s.pd && !core_reset
      && pc_value == PC_W'($past(pc_in) + PC_W'(1)))
      else $error("watchdog wake did not resume at next address");

   irq_wake_a: assert property (ev_irq |=> s.to && !s.pd && !core_reset)
      else $error("interrupt wake status wrong");

   ri_only_a: assert property (ev_ri && !wr_en |=> !s.power_control_flags_0[RI_BIT]
      && (s.power_control_flags_0 | 8'h04) == ($past(s.power_control_flags_0) | 8'h04))
      else $error("reset instruction touched other flags");

   stack_a: assert property ((ev_ovf || ev_unf) |=> core_reset
      && (s.power_control_flags_0[OVF_BIT] || s.power_control_flags_0[UNF_BIT]))
      else $error("stack reset flag not set");

   exec_violation_flag_a: assert property (ev_exec_violation_flag && !wr_en |=> !s.exec_violation_flag
      && $stable(s.power_control_flags_0) && core_reset)
      else $error("execution violation wrong");

   sticky_a: assert property (!ev_any && !wr_en
      |=> $stable(s.power_control_flags_0) && $stable(s.exec_violation_flag))
      else $error("flag changed with no cause");

   sw_set_a: assert property (wr_en && addr == POWER_CONTROL_FLAGS_0_OFS && !ev_any
      |=> s.power_control_flags_0 == $past(wdata) && !core_reset)
      else $error("software flag write not stored");

   // Bus side: read data stand one cycle only, status not writable
   rdata_idle_a: assert property (!rd_en |=> rdata == '0)
      else $error("read data not zero outside read slot");

   read_flags_a: assert property (rd_en && addr == POWER_CONTROL_FLAGS_0_OFS
      |=> rdata == $past(s.power_control_flags_0))
      else $error("flag register read wrong");

   read_status_a: assert property (rd_en && addr == STATUS_OFS
      |=> rdata[TO_BIT] == $past(s.to) && rdata[PD_BIT] == $past(s.pd))
      else $error("status register read wrong");

   status_ro_a: assert property (wr_en && addr == STATUS_OFS && !ev_any
      |=> $stable({s.to, s.pd}))
      else $error("status bits took a software write");

   exec_violation_flag_write_a: assert property (wr_en && addr == POWER_CONTROL_FLAGS_1_OFS && !ev_any
      |=> s.exec_violation_flag == $past(wdata[EXEC_VIOLATION_FLAG_BIT]) && !core_reset)
      else $error("second flag register write not stored");

   // Restart pulses: one cycle, always to the reset address
   reset_pulse_a: assert property (core_reset |=> !core_reset)
      else $error("restart pulse longer than one cycle");

   restart_vec_a: assert property (core_reset
      |-> pc_load && pc_value == PC_W'(RESET_VEC))
      else $error("restart without reset address");

   ovf_set_a: assert property (ev_ovf |=> s.power_control_flags_0[OVF_BIT] && core_reset)
      else $error("overflow flag not set");

   unf_set_a: assert property (ev_unf |=> s.power_control_flags_0[UNF_BIT] && core_reset)
      else $error("underflow flag not set");

   stack_off_a: assert property ((stack_overflow || stack_underflow) && !s.stk_en
      && !ev_any |=> !core_reset)
      else $error("stack event reset while disabled");

   lp_bor_a: assert property (low_power_brownout_req
      |=> !s.power_control_flags_0[BOR_BIT] && core_reset)
      else $error("low-power brown-out did not clear flag");

   irq_no_gie_a: assert property (ev_irq && !global_interrupt_enable
      |=> !s.vector_pending)
      else $error("vector armed with interrupts disabled");

   wake_keep_a: assert property ((ev_wdt_wake || ev_irq) && !wr_en
      |=> $stable(s.power_control_flags_0) && $stable(s.exec_violation_flag))
      else $error("wake-up changed a flag");

   por_keep_a: assert property (ev_any && !ev_bor && !wr_en
      |=> s.power_control_flags_0[POR_BIT] == $past(s.power_control_flags_0[POR_BIT]))
      else $error("power-on flag changed by other cause");

   pin_pc_a: assert property (ev_pin
      |=> pc_load && pc_value == PC_W'(RESET_VEC))
      else $error("pin reset did not restart at zero");

   irq_resume_a: assert property (ev_irq
      |=> pc_load && pc_value == PC_W'($past(pc_in) + PC_W'(1)))
      else $error("interrupt wake did not resume at next address");

endmodule

// ===== reset_cause_pkg.sv
package reset_cause_pkg;

   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] POWER_CONTROL_FLAGS_0_OFS  = 8'h01;
   localparam logic [7:0] POWER_CONTROL_FLAGS_1_OFS  = 8'h02;
   localparam logic [7:0] CTRL_OFS   = 8'h03;

   // Field positions in power_control_flags_0
   localparam int OVF_BIT = 7;
   localparam int UNF_BIT = 6;
   localparam int WIN_BIT = 5;
   localparam int WDT_BIT = 4;
   localparam int PIN_BIT = 3;
   localparam int RI_BIT  = 2;
   localparam int POR_BIT = 1;
   localparam int BOR_BIT = 0;

   // Field positions elsewhere
   localparam int EXEC_VIOLATION_FLAG_BIT   = 1;
   localparam int TO_BIT     = 4;
   localparam int PD_BIT     = 3;
   localparam int STK_EN_BIT = 0;

   // Reset values
   localparam logic [7:0] POWER_CONTROL_FLAGS_0_POR  = 8'h3C;
   localparam logic       EXEC_VIOLATION_FLAG_POR   = 1'h1;
   localparam logic       STK_EN_POR = 1'h1;

   // Brown-out image: stack flags low, four flags high, brown-out low
   localparam logic [7:0] POWER_CONTROL_FLAGS_0_BOR_SET = 8'h3C;
   localparam logic [7:0] POWER_CONTROL_FLAGS_0_BOR_KEEP = 8'h02;

   // Program counter targets
   localparam int         PC_BITS    = 15;
   localparam logic [14:0] RESET_VEC = 15'h0000;
   localparam logic [14:0] IRQ_VEC   = 15'h0004;

endpackage

// ===== core_stub.sv
`timescale 1ns/10ps
// Stand-in for the processor core on the far side of the block
module core_stub
   import reset_cause_pkg::*;
#(
   parameter int DELAY = 3
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               pc_load,
   input  wire logic [PC_BITS-1:0] pc_value,
   input  wire logic               push_return,
   input  wire logic               core_reset,
   output logic                    instr_done,
   output logic      [PC_BITS-1:0] pc_in
);
   int count;

   // Track the PC; after a wake run the resume instruction, then retire it
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc_in <= '0;
         count <= 0;
         instr_done <= 1'b0;
      end else begin
         instr_done <= (count == 1);
         if (count > 0) begin
            count <= count - 1;
         end
         if (pc_load) begin
            pc_in <= pc_value;
            // A real restart never retires the resume instruction
            if (!core_reset && !push_return) begin
               count <= DELAY;
            end
         end
         if (core_reset) begin
            count <= 0;
         end
      end
   end
endmodule

// ===== reset_cause_flags_tb.sv
`timescale 1ns/10ps
module reset_cause_flags_tb
   import reset_cause_pkg::*;
;
   typedef struct packed {
      logic [8:0]  ev;
      logic        slp;
      logic [7:0]  pre;
      logic [7:0]  f0;
      logic [7:0]  f1;
      logic [1:0]  st;
      logic        rs;
      logic [14:0] pcv;
   } row_t;

   logic        clock, rst, wr_en, rd_en, master_clear_pin_n, sleeping;
   logic        global_interrupt_enable, instr_done, cr;
   logic        timeout_status, powerdown_status, core_reset, pc_load, push_return;
   logic [7:0]  addr, wdata, rdata;
   logic [8:0]  ev;
   logic [14:0] pc_in, pc_value, pv;
   int          num_errors, checks, cycles, n_resets, k;

   // Event bits: bor low_power_brownout exec wdt win ri ovf unf irq, low to high
   row_t rows [13] = '{
      '{9'h010, 1'h0, 8'hFF, 8'hDF, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h020, 1'h0, 8'hFF, 8'hFB, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h040, 1'h0, 8'h00, 8'h80, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h080, 1'h0, 8'h00, 8'h40, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h008, 1'h0, 8'hFF, 8'hEF, 8'h02, 2'h1, 1'h1, 15'h0000},
      '{9'h100, 1'h1, 8'h5A, 8'h5A, 8'h02, 2'h2, 1'h0, 15'h0001},
      '{9'h008, 1'h1, 8'h5A, 8'h5A, 8'h02, 2'h0, 1'h0, 15'h0002},
      '{9'h001, 1'h0, 8'hFF, 8'h3E, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h002, 1'h0, 8'h01, 8'h3C, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h004, 1'h0, 8'hAA, 8'hAA, 8'h00, 2'h3, 1'h1, 15'h0000},
      '{9'h011, 1'h0, 8'hFF, 8'h3E, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h060, 1'h0, 8'h00, 8'h00, 8'h02, 2'h3, 1'h1, 15'h0000},
      '{9'h100, 1'h0, 8'h5A, 8'h5A, 8'h02, 2'h3, 1'h0, 15'h0000}
   };

   reset_cause_flags reset_cause_flags_inst (
      .clock, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .master_clear_pin_n,
      .brownout_req(ev[0]), .low_power_brownout_req(ev[1]), .exec_violation(ev[2]),
      .wdt_timeout(ev[3]), .window_violation(ev[4]), .reset_instr(ev[5]),
      .stack_overflow(ev[6]), .stack_underflow(ev[7]), .irq_wake(ev[8]),
      .sleeping, .global_interrupt_enable, .instr_done, .pc_in, .timeout_status,
      .powerdown_status, .core_reset, .pc_load, .pc_value, .push_return
   );

   core_stub core_stub_inst (
      .clock, .rst, .pc_load, .pc_value, .push_return, .core_reset, .instr_done, .pc_in
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Count restarts and cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (core_reset === 1'b1) n_resets++;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 chk($sformatf("rdata at %h", a), {8'h00, e}, {8'h00, rdata});
   endtask

   task automatic pulse(input logic [8:0] e, input logic s);
      @(posedge clock);
      ev <= e;
      sleeping <= s;
      @(posedge clock);
      ev <= 9'h000;
      #1 cr = core_reset;
      pv = pc_value;
   endtask

   task automatic reset_vals(input string n);
      chk("status pins", 16'h0003, {14'h0, timeout_status, powerdown_status});
      chk("pc_value", 16'h0000, {1'b0, pc_value});
      rchk(STATUS_OFS, 8'h18);
      rchk(POWER_CONTROL_FLAGS_0_OFS, 8'h3C);
      rchk(POWER_CONTROL_FLAGS_1_OFS, 8'h02);
      rchk(CTRL_OFS, 8'h01);
      rchk(8'h7F, 8'h00);
      $display("test %s done", n);
   endtask

   // Pin pulled low, filtered, then released; one restart expected
   task automatic pin_reset(input logic s, input logic [1:0] st);
      int n;
      wr(POWER_CONTROL_FLAGS_0_OFS, 8'hFF);
      @(posedge clock);
      n = n_resets;
      sleeping <= s;
      master_clear_pin_n <= 1'b0;
      repeat (8) @(posedge clock);
      master_clear_pin_n <= 1'b1;
      sleeping <= 1'b0;
      chk("pin restarts", 16'h0001, 16'(n_resets - n));
      chk("pin status", {14'h0, st}, {14'h0, timeout_status, powerdown_status});
      rchk(POWER_CONTROL_FLAGS_0_OFS, 8'hF7);
      rchk(POWER_CONTROL_FLAGS_1_OFS, 8'h02);
      repeat (4) @(posedge clock);
      $display("test pin reset sleep %0b done", s);
   endtask

   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      master_clear_pin_n = 1'b1;
      ev = 9'h000;
      sleeping = 1'b0;
      global_interrupt_enable = 1'b0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      reset_vals("reset values");
      for (int i = 0; i < 13; i++) begin
         wr(POWER_CONTROL_FLAGS_0_OFS, rows[i].pre);
         wr(POWER_CONTROL_FLAGS_1_OFS, 8'h02);
         pulse(rows[i].ev, rows[i].slp);
         chk("core_reset", {15'h0, rows[i].rs}, {15'h0, cr});
         chk("pc_value", {1'b0, rows[i].pcv}, {1'b0, pv});
         chk("status", {14'h0, rows[i].st}, {14'h0, timeout_status, powerdown_status});
         rchk(POWER_CONTROL_FLAGS_0_OFS, rows[i].f0);
         rchk(POWER_CONTROL_FLAGS_1_OFS, rows[i].f1);
         $display("test row %0d done", i);
      end
      pin_reset(1'b0, 2'h3);
      pin_reset(1'b1, 2'h2);
      // Interrupt wake with interrupts on: resume, then vector
      @(posedge clock);
      global_interrupt_enable <= 1'b1;
      pulse(9'h100, 1'b1);
      chk("wake pc", 16'h0001, {1'b0, pv});
      for (k = 0; k < 20 && push_return !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      sleeping <= 1'b0;
      chk("push", 16'h0001, {15'h0, push_return});
      chk("vector", 16'h0004, {1'b0, pc_value});
      $display("test vector done");
      // Stack events with the enable off
      wr(CTRL_OFS, 8'h00);
      wr(POWER_CONTROL_FLAGS_0_OFS, 8'h00);
      pulse(9'h0C0, 1'b0);
      chk("stack off reset", 16'h0000, {15'h0, cr});
      rchk(POWER_CONTROL_FLAGS_0_OFS, 8'h00);
      wr(CTRL_OFS, 8'h01);
      // Software sets flags: stored, no restart, status not writable
      k = n_resets;
      wr(POWER_CONTROL_FLAGS_0_OFS, 8'hFF);
      wr(STATUS_OFS, 8'h00);
      repeat (50) @(posedge clock);
      rchk(POWER_CONTROL_FLAGS_0_OFS, 8'hFF);
      rchk(STATUS_OFS, 8'h10);
      chk("soft restarts", 16'(k), 16'(n_resets));
      $display("test software flags done");
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      reset_vals("second reset");
      final_report();
   end
endmodule
